// [verilog/i2c_status_pkg.sv]
// Package with offsets, bit positions, reset values and responses for status flags
package i2c_status_pkg;
    // Register byte offsets on the AXI4-Lite slave
    localparam logic [3:0] status_offset = 4'h0;
    localparam logic [3:0] irq_status_offset = 4'h4;
    localparam logic [3:0] irq_mask_offset = 4'h8;
    localparam logic [3:0] control_offset = 4'hc;
    // Bit positions in bus_status_flags
    localparam int ack_bit = 15;
    localparam int txp_bit = 14;
    localparam int bcl_bit = 10;
    localparam int gc_bit = 9;
    localparam int ten_bit = 8;
    localparam int wcol_bit = 7;
    localparam int ovf_bit = 6;
    localparam int da_bit = 5;
    localparam int stop_bit = 4;
    // Software-clearable flags: collision, write collision, overflow
    localparam logic [15:0] clearable_mask = 16'h04c0;
    // Implemented bits; 13..11 and the low nibble read zero
    localparam logic [15:0] implemented_mask = 16'hc7f0;
    // Reset values
    localparam logic [15:0] status_reset = 16'h0000;
    localparam logic [7:0] own_addr_reset = 8'h00;
    // Event bit positions in interrupt status
    localparam int ev_nack = 0;
    localparam int ev_bcl = 1;
    localparam int ev_gc = 2;
    localparam int ev_wcol = 3;
    localparam int ev_ovf = 4;
    localparam int ev_stop = 5;
    localparam int ev_count = 6;
    // AXI responses
    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;
endpackage

// [verilog/i2c_status_flags.sv]
// Status-flag logic of a two-wire bus peripheral with an AXI4-Lite slave
`timescale 1ns/1ps
module i2c_status_flags
    import i2c_status_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // Two-wire bus lines as seen at the pins
    input wire logic scl_in,
    input wire logic sda_in,
    // Engine state from the shifter/master logic on aclk
    input wire logic master_active,
    input wire logic master_tx_mode,
    input wire logic master_tx_start,
    input wire logic bus_collision,
    input wire logic tx_write,
    input wire logic engine_busy,
    input wire logic rx_byte_done,
    input wire logic rx_is_address,
    input wire logic [7:0] rx_byte,
    input wire logic rx_holding_full,
    input wire logic ten_bit_second,
    // AXI4-Lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Level interrupt
    output logic irq
);

    // Stage helper: settled when second and third flops agree
    function automatic logic settle(input logic [2:0] s, input logic old);
        settle = (s[1] == s[2]) ? s[1] : old;
    endfunction

    // Three-flop samplers for the bus lines
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic scl_reg;
    logic sda_reg;
    logic scl_next;
    logic sda_next;

    // Flag storage
    logic ack_result_flag_reg;
    logic tx_in_progress_flag_reg;
    logic bus_collision_flag_reg;
    logic general_call_hit_flag_reg;
    logic ten_bit_match_flag_reg;
    logic write_collision_flag_reg;
    logic rx_overflow_flag_reg;
    logic data_addr_flag_reg;
    logic stop_seen_flag_reg;
    // Master ack bit capture
    logic [3:0] bit_count_reg;
    logic ack_sample_reg;

    // Interrupt and control registers
    logic [ev_count-1:0] irq_status_reg;
    logic [ev_count-1:0] irq_mask_reg;
    logic [7:0] own_addr_reg;

    // Bus handshake state
    logic aw_held_reg;
    logic w_held_reg;
    logic [3:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    // Strobes travel with held data; the master may drop them early
    logic [3:0] w_strb_reg;

    // Settled line levels
    assign scl_next = settle(scl_sync_reg, scl_reg);
    assign sda_next = settle(sda_sync_reg, sda_reg);

    // Start or repeated start: data falls while clock high
    wire start_det = scl_reg && scl_next && sda_reg && !sda_next;
    // Stop: data rises while clock high
    wire stop_det = scl_reg && scl_next && !sda_reg && sda_next;
    // Rising clock edge, used to count master bits
    wire scl_rise = !scl_reg && scl_next;
    // Ninth rising edge is the slave acknowledge
    wire ack_edge = scl_rise && tx_in_progress_flag_reg &&
                    (bit_count_reg == 4'h8);
    // End of acknowledge: clock falls after the ninth bit
    wire ack_end = scl_reg && !scl_next && tx_in_progress_flag_reg &&
                   (bit_count_reg == 4'h9);

    wire gc_match = rx_byte_done && rx_is_address && (rx_byte == 8'h00);
    wire own_match = rx_byte_done && rx_is_address &&
                     (rx_byte[7:1] == own_addr_reg[7:1]);
    wire wcol_event = tx_write && engine_busy;
    wire ovf_event = rx_byte_done && rx_holding_full;
    wire bcl_event = bus_collision && master_active;

    // Status word as software sees it
    wire [15:0] status_word = implemented_mask & {
        ack_result_flag_reg, tx_in_progress_flag_reg, 3'b000,
        bus_collision_flag_reg, general_call_hit_flag_reg,
        ten_bit_match_flag_reg, write_collision_flag_reg,
        rx_overflow_flag_reg, data_addr_flag_reg, stop_seen_flag_reg,
        4'h0};

    // Hardware events in interrupt layout
    wire [ev_count-1:0] events = {stop_det, ovf_event, wcol_event,
                                  gc_match, bcl_event, ack_end & ack_sample_reg};

    // Write fires once both address and data are in hand
    wire aw_now = s_axi_awvalid && s_axi_awready;
    wire w_now = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held_reg || aw_now;
    wire w_have = w_held_reg || w_now;
    wire wr_fire = aw_have && w_have && !s_axi_bvalid;
    wire [3:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
    wire [3:0] wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
    wire wr_status = wr_fire && (wr_addr == status_offset);
    wire wr_mask = wr_fire && (wr_addr == irq_mask_offset);
    wire wr_ctrl = wr_fire && (wr_addr == control_offset);
    wire wr_known = wr_status || wr_mask || wr_ctrl ||
                    (wr_fire && (wr_addr == irq_status_offset));
    // Strobe 0 gates the low status, mask and control lanes; strobe 1 gates the collision bit
    wire lane0 = wr_strb[0];
    wire lane1 = wr_strb[1];
    // Software clears a flag by writing zero to it
    wire clr_wcol = wr_status && lane0 && !wr_data[wcol_bit];
    wire clr_ovf = wr_status && lane0 && !wr_data[ovf_bit];
    wire clr_bcl = wr_status && lane1 && !wr_data[bcl_bit];

    // Read decode
    wire rd_fire = s_axi_arvalid && s_axi_arready;
    wire rd_irq = rd_fire && (s_axi_araddr == irq_status_offset);
    logic [31:0] rd_word;
    logic rd_ok;
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        if (s_axi_araddr == status_offset)
        begin
            rd_word = {16'h0000, status_word};
        end
        else if (s_axi_araddr == irq_status_offset)
        begin
            rd_word = {26'h0, irq_status_reg};
        end
        else if (s_axi_araddr == irq_mask_offset)
        begin
            rd_word = {26'h0, irq_mask_reg};
        end
        else if (s_axi_araddr == control_offset)
        begin
            rd_word = {24'h0, own_addr_reg};
        end
        else
        begin
            // Unmapped address
            rd_ok = 1'b0;
        end
    end

    // Bus-line samplers; only the last two stages feed logic
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end
        else if (clk_en)
        begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
            scl_reg <= scl_next;
            sda_reg <= sda_next;
        end
    end

    // Master transmit tracking and ack capture
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_in_progress_flag_reg <= 1'b0;
            ack_result_flag_reg <= 1'b0;
            ack_sample_reg <= 1'b0;
            bit_count_reg <= 4'h0;
        end
        else if (clk_en)
        begin
            if (master_tx_start && master_tx_mode)
            begin
                tx_in_progress_flag_reg <= 1'b1;
                bit_count_reg <= 4'h0;
            end
            else if (ack_end)
            begin
                tx_in_progress_flag_reg <= 1'b0;
                ack_result_flag_reg <= ack_sample_reg;
            end
            else if (scl_rise && tx_in_progress_flag_reg)
            begin
                bit_count_reg <= bit_count_reg + 4'h1;
            end
            // Sample data on the ninth clock high
            if (ack_edge)
            begin
                ack_sample_reg <= sda_next;
            end
        end
    end

    // Address, data and condition flags
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            general_call_hit_flag_reg <= 1'b0;
            ten_bit_match_flag_reg <= 1'b0;
            data_addr_flag_reg <= 1'b0;
            stop_seen_flag_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (gc_match)
                general_call_hit_flag_reg <= 1'b1;
            else if (stop_det)
                general_call_hit_flag_reg <= 1'b0;
            if (ten_bit_second)
                ten_bit_match_flag_reg <= 1'b1;
            else if (stop_det)
                ten_bit_match_flag_reg <= 1'b0;
            if (own_match || gc_match)
                data_addr_flag_reg <= 1'b0;
            else if (rx_byte_done && !rx_is_address && !master_active)
                data_addr_flag_reg <= 1'b1;
            if (stop_det)
                stop_seen_flag_reg <= 1'b1;
            else if (start_det)
                stop_seen_flag_reg <= 1'b0;
        end
    end

    // Software-cleared error flags; a new event beats the clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bus_collision_flag_reg <= 1'b0;
            write_collision_flag_reg <= 1'b0;
            rx_overflow_flag_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (bcl_event)
                bus_collision_flag_reg <= 1'b1;
            else if (clr_bcl)
                bus_collision_flag_reg <= 1'b0;
            if (wcol_event)
                write_collision_flag_reg <= 1'b1;
            else if (clr_wcol)
                write_collision_flag_reg <= 1'b0;
            if (ovf_event)
                rx_overflow_flag_reg <= 1'b1;
            else if (clr_ovf)
                rx_overflow_flag_reg <= 1'b0;
        end
    end

    // Interrupt status: read clears, events win over the clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_status_reg <= '0;
            irq_mask_reg <= '0;
            own_addr_reg <= own_addr_reset;
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            irq_status_reg <= (rd_irq ? '0 : irq_status_reg) | events;
            if (wr_mask && lane0)
                irq_mask_reg <= wr_data[ev_count-1:0];
            if (wr_ctrl && lane0)
                own_addr_reg <= wr_data[7:0];
            // One cycle behind status, registered output
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // AXI4-Lite write channel; address and data in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= resp_okay;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end
        else if (clk_en)
        begin
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? resp_okay : resp_slverr;
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
            end
            else
            begin
                if (aw_now)
                begin
                    aw_held_reg <= 1'b1;
                    aw_addr_reg <= s_axi_awaddr;
                end
                if (w_now)
                begin
                    w_held_reg <= 1'b1;
                    w_data_reg <= s_axi_wdata;
                    w_strb_reg <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready)
                    s_axi_bvalid <= 1'b0;
                // Ready only while that half is still missing
                s_axi_awready <= !aw_have && !s_axi_bvalid;
                s_axi_wready <= !w_have && !s_axi_bvalid;
            end
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= resp_okay;
        end
        else if (clk_en)
        begin
            if (rd_fire)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? resp_okay : resp_slverr;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
            else
            begin
                s_axi_arready <= !s_axi_rvalid;
            end
        end
    end

endmodule

// [tb/i2c_status_checker.sv]
// Checker for the status-flag block's register bus and read values
`timescale 1ns/1ps
module i2c_status_checker
    import i2c_status_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Address of the read in flight
    logic [3:0] rd_addr_reg;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Latch the read address so the answer can be judged by target
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rd_addr_reg <= 4'h0;
        else if (clk_en && s_axi_arvalid && s_axi_arready)
            rd_addr_reg <= s_axi_araddr;
    end
    chk_ready_rst: assert property ($rose(aresetn) |-> ##[0:1]
        (s_axi_arready && s_axi_awready && s_axi_wready))
        else $error("readies not raised after reset");
    chk_read_latency: assert property (clk_en && s_axi_arvalid
        && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_write_latency: assert property (clk_en && s_axi_awvalid
        && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write answer late");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped or changed");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped or changed");
    // Only one read or one write may be under way
    chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    chk_write_refuse: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    chk_status_zeros: assert property (s_axi_rvalid &&
        rd_addr_reg == status_offset |-> s_axi_rdata[13:11] == 3'h0
        && s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[31:16] == 16'h0)
        else $error("unimplemented status bits not zero");
    // Unaligned addresses hold no register
    chk_unmapped_err: assert property (s_axi_rvalid &&
        rd_addr_reg[1:0] != 2'h0 |-> s_axi_rresp == resp_slverr
        && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule

bind i2c_status_flags i2c_status_checker u_chk (.*);

// [tb/i2c_remote_model.sv]
// Remote two-wire party that drives clock and data lines
`timescale 1ns/1ps
module i2c_remote_model
(
    output logic scl,
    output logic sda
);
    // Released lines sit high through the pull-ups
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Start: data falls while clock is high
    // Each task steps off the aclk edge so samplers never race the lines
    task start_c();
        #2;
        sda = 1'b0;
        #32;
        scl = 1'b0;
        #32;
    endtask
    // Eight bits then the acknowledge slot, msb first, 64 ns a bit
    task byte9(input logic [8:0] bits);
        int i;
        #2;
        for (i = 8; i >= 0; i--)
        begin
            // Data only moves while clock is low
            sda = bits[i];
            #8;
            scl = 1'b1;
            #32;
            scl = 1'b0;
            #24;
        end
        // Pull data low so a later stop has a rising edge
        sda = 1'b0;
        #64;
    endtask
    // Stop: data rises while clock is high, then lines released
    task stop_c();
        #2;
        sda = 1'b0;
        #8;
        scl = 1'b1;
        #32;
        sda = 1'b1;
        #64;
    endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the status-flag block
`timescale 1ns/1ps
module tb_top
    import i2c_status_pkg::*;
;
    logic aclk, aresetn, clk_en;
    wire scl_in, sda_in;
    logic master_active, master_tx_mode, engine_busy;
    logic rx_is_address, rx_holding_full;
    // Event pulses: start, collision, tx write, rx done, ten-bit
    logic [4:0] ev;
    logic [7:0] rx_byte;
    wire master_tx_start = ev[0];
    wire bus_collision = ev[1];
    wire tx_write = ev[2];
    wire rx_byte_done = ev[3];
    wire ten_bit_second = ev[4];
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    int n_mismatch, n_checks;
    // Last read word and response
    logic [31:0] rd_d;
    logic [1:0] rd_r;
    // Last write response
    logic [1:0] wr_r;
    logic [6:0] own;

    i2c_status_flags u_dut (.*);
    i2c_remote_model u_peer (.scl(scl_in), .sda(sda_in));

    // 125 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task complete_run();
        if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bus write: both halves offered together, bready held up
    task wr(input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 40; i++)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
                break;
        end
        wr_r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // Hung bus ends the run
        if (i == 40)
        begin
            n_mismatch++;
            complete_run();
        end
    endtask

    task rd(input logic [3:0] a);
        int i;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 40; i++)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                break;
        end
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (i == 40)
        begin
            n_mismatch++;
            complete_run();
        end
    endtask

    // Read status and compare one flag
    task stb(input int b, input logic v);
        rd(status_offset);
        cmp({31'h0, rd_d[b]}, {31'h0, v});
    endtask

    task pulse(input int k);
        @(posedge aclk);
        ev[k] <= 1'b1;
        @(posedge aclk);
        ev <= 5'h0;
    endtask

    // Software clear: zero written to one flag only
    task clr(input int b);
        wr(status_offset, 32'h0000ffff ^ (32'h1 << b));
    endtask

    initial
    begin
        {aresetn, master_active, master_tx_mode, engine_busy} = 4'h0;
        {rx_is_address, rx_holding_full, ev, rx_byte} = 15'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_wstrb = 4'hf;
        clk_en = 1'b1;
        n_mismatch = 0;
        n_checks = 0;
        own = 7'($urandom(35));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values and an unmapped place
        rd(status_offset);
        cmp(rd_d, 32'h0);
        rd(irq_mask_offset);
        cmp(rd_d, 32'h0);
        rd(4'h2);
        cmp({30'h0, rd_r}, {30'h0, resp_slverr});
        wr(irq_mask_offset, 32'h3f);
        cmp({30'h0, wr_r}, {30'h0, resp_okay});
        rd(irq_mask_offset);
        cmp(rd_d, 32'h3f);
        wr(4'h6, 32'h0);
        cmp({30'h0, wr_r}, {30'h0, resp_slverr});
        master_active <= 1'b1;
        master_tx_mode <= 1'b1;
        u_peer.start_c();
        stb(stop_bit, 1'b0);
        // Byte answered with a refusal
        pulse(0);
        stb(txp_bit, 1'b1);
        u_peer.byte9({8'($urandom), 1'b1});
        stb(txp_bit, 1'b0);
        stb(ack_bit, 1'b1);
        cmp({31'h0, irq}, 32'h1);
        rd(irq_status_offset);
        cmp(rd_d, 32'h1 << ev_nack);
        rd(irq_status_offset);
        cmp({31'h0, irq}, 32'h0);
        // Byte answered with an acknowledge
        pulse(0);
        u_peer.byte9({8'($urandom), 1'b0});
        stb(ack_bit, 1'b0);
        // Collision sticks until cleared
        pulse(1);
        stb(bcl_bit, 1'b1);
        repeat (20) @(posedge aclk);
        stb(bcl_bit, 1'b1);
        clr(bcl_bit);
        stb(bcl_bit, 1'b0);
        master_active <= 1'b0;
        pulse(1);
        stb(bcl_bit, 1'b0);
        // Write while busy fails, idle write does not
        engine_busy <= 1'b1;
        pulse(2);
        stb(wcol_bit, 1'b1);
        engine_busy <= 1'b0;
        clr(wcol_bit);
        pulse(2);
        stb(wcol_bit, 1'b0);
        // Busy write while frozen must leave no trace
        clk_en <= 1'b0;
        engine_busy <= 1'b1;
        pulse(2);
        {clk_en, engine_busy} <= 2'b10;
        stb(wcol_bit, 1'b0);
        // Data byte into a full holding register
        rx_holding_full <= 1'b1;
        rx_byte <= 8'($urandom);
        pulse(3);
        stb(ovf_bit, 1'b1);
        stb(da_bit, 1'b1);
        rx_holding_full <= 1'b0;
        clr(ovf_bit);
        stb(ovf_bit, 1'b0);
        // Own address, then general call and ten-bit match
        wr(control_offset, {24'h0, own, 1'b0});
        rx_is_address <= 1'b1;
        rx_byte <= {own, 1'b0};
        pulse(3);
        stb(da_bit, 1'b0);
        rx_byte <= 8'h00;
        pulse(3);
        stb(gc_bit, 1'b1);
        pulse(4);
        stb(ten_bit, 1'b1);
        u_peer.stop_c();
        stb(gc_bit, 1'b0);
        stb(ten_bit, 1'b0);
        stb(stop_bit, 1'b1);
        u_peer.start_c();
        stb(stop_bit, 1'b0);
        // Masked event leaves the interrupt low
        rd(irq_status_offset);
        wr(irq_mask_offset, 32'h0);
        master_active <= 1'b1;
        pulse(1);
        repeat (4) @(posedge aclk);
        cmp({31'h0, irq}, 32'h0);
        rd(irq_status_offset);
        cmp(rd_d, 32'h1 << ev_bcl);
        complete_run();
    end
endmodule
